// ==== rtl/dpll_tm_pkg.sv ====
// Purpose: Shared constants and types for the translation mode control block
// Assumes: 16-bit APB byte addresses, 32-bit data
// Notes: Profile word holds enable/priority, source, feedback select and mode bytes
package dpll_tm_pkg;
  localparam logic [15:0] PROF_BASE0 = 16'h1200;
  localparam logic [15:0] PROF_BASE1 = 16'h1600;
  localparam logic [7:0] PROF_END = 8'hC0;
  localparam logic [15:0] CH_BASE = 16'h2000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DIV = 8'h04;
  localparam logic [7:0] OFS_FRAC = 8'h08;
  localparam logic [7:0] OFS_LIMIT = 8'h0C;
  localparam logic [7:0] OFS_FREQ = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_BO = 8'h18;
  localparam logic [7:0] OFS_FADJ = 8'h1C;
  localparam logic [7:0] OFS_RNUM = 8'h20;
  localparam logic [7:0] OFS_RDEN = 8'h24;
  localparam int EN_BIT = 0;
  localparam int SRC_LSB = 8;
  localparam int FBS_LSB = 16;
  localparam int MODE_LSB = 24;
  localparam int ACQ_BIT = 3;
  localparam logic [31:0] PROF_MASK = 32'h031F1F3F;
  localparam logic [31:0] PROF_RST = 32'h00000000;
  localparam logic [31:0] DIV_RST = 32'h01010101;
  localparam logic [31:0] FRAC_RST = 32'h00000100;
  localparam logic [4:0] SRC_FB_A = 5'h04;
  localparam logic [4:0] SRC_FB_B = 5'h05;
  localparam logic [4:0] SRC_NCO0 = 5'h08;
  localparam logic [4:0] SRC_NCO1 = 5'h09;
  localparam int STEER_SHIFT = 2;
  typedef enum logic [1:0] {
    MODE_BUILDOUT = 2'h0,
    MODE_INT_ZD = 2'h1,
    MODE_RSVD = 2'h2,
    MODE_EXT_ZD = 2'h3
  } tmode_t;
endpackage

// ==== rtl/acq_if.sv ====
// Purpose: Carrier between register block and acquisition engine
// Assumes: Same clock on both sides
// Notes: Offsets and frequencies are signed
`timescale 1ns/10ps
`default_nettype none
interface acq_if;
  logic start;
  logic [1:0] mode;
  logic signed [15:0] offset;
  logic signed [15:0] period;
  logic signed [15:0] slew;
  logic signed [15:0] clamp;
  logic signed [15:0] freq_in;
  logic signed [15:0] bo;
  logic signed [15:0] fadj;
  logic hitless;
  logic busy;
  modport ctl (output start, mode, offset, period, slew, clamp, freq_in,
    input bo, fadj, hitless, busy);
  modport eng (input start, mode, offset, period, slew, clamp, freq_in,
    output bo, fadj, hitless, busy);
endinterface
`default_nettype wire

// ==== rtl/tm_engine.sv ====
// Purpose: Per-channel acquisition engine for buildout and hitless modes
// Assumes: Start is a one-cycle pulse; slew or clamp of zero means disabled
// Notes: Outputs are registered
`timescale 1ns/10ps
`default_nettype none
module tm_engine (
  input wire logic pclk,
  input wire logic presetn,
  acq_if.eng acq
);
  typedef enum logic [1:0] {IDLE, BUILD, STEER} state_t;
  typedef struct packed {
    state_t state;
    logic signed [15:0] bo;
    logic signed [15:0] target;
    logic signed [15:0] fadj;
    logic hitless;
  } eng_t;
  eng_t s_ff, nxt_s;

  function automatic logic signed [15:0] lim(input logic signed [16:0] v,
                                             input logic signed [15:0] l);
    logic signed [16:0] l17;
    l17 = 17'(l);
    if (l <= 0) lim = 16'(v);
    else if (v > l17) lim = l;
    else if (v < -l17) lim = -l;
    else lim = 16'(v);
  endfunction

  // Pick the nearest reference edge so steering never runs the long way round
  function automatic logic signed [15:0] wrap(input logic signed [15:0] o,
                                              input logic signed [15:0] p);
    logic signed [16:0] o17;
    logic signed [16:0] p17;
    o17 = 17'(o);
    p17 = 17'(p);
    if (p <= 0) wrap = o;
    else if (o17 > (p17 >>> 1)) wrap = 16'(o17 - p17);
    else if (o17 < -(p17 >>> 1)) wrap = 16'(o17 + p17);
    else wrap = o;
  endfunction

  always_comb begin
    logic signed [15:0] pull;
    logic signed [15:0] tot;
    pull = 16'sh0000;
    tot = 16'sh0000;
    nxt_s = s_ff;
    if (acq.start) begin
      nxt_s.fadj = acq.freq_in;
      if (acq.mode == dpll_tm_pkg::MODE_INT_ZD || acq.mode == dpll_tm_pkg::MODE_EXT_ZD) begin
        nxt_s.target = wrap(acq.offset, acq.period);
        nxt_s.state = BUILD;
        nxt_s.hitless = 1'b1;
      end else begin
        // Reserved code runs as buildout; step inserted at once, unslewed
        nxt_s.bo = acq.offset;
        nxt_s.state = IDLE;
        nxt_s.hitless = 1'b0;
      end
    end else begin
      case (s_ff.state)
        IDLE: begin
          nxt_s.fadj = acq.freq_in;
        end
        BUILD: begin
          nxt_s.bo = 16'(17'(s_ff.bo) + 17'(lim(17'(s_ff.target) - 17'(s_ff.bo), acq.slew)));
          if (nxt_s.bo == s_ff.target) nxt_s.state = STEER;
        end
        STEER: begin
          pull = s_ff.bo >>> dpll_tm_pkg::STEER_SHIFT;
          if (pull == 0 && s_ff.bo != 0) pull = s_ff.bo[15] ? -16'sh0001 : 16'sh0001;
          pull = lim(17'(pull), acq.slew);
          tot = lim(17'(acq.freq_in) + 17'(pull), acq.clamp);
          nxt_s.fadj = tot;
          nxt_s.bo = 16'(17'(s_ff.bo) - (17'(tot) - 17'(acq.freq_in)));
          if (s_ff.bo == 0) begin
            nxt_s.state = IDLE;
            nxt_s.hitless = 1'b0;
            nxt_s.fadj = acq.freq_in;
          end
        end
        default: nxt_s.state = IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_ff <= '0;
    else s_ff <= nxt_s;
  end

  assign acq.bo = s_ff.bo;
  assign acq.fadj = s_ff.fadj;
  assign acq.hitless = s_ff.hitless;
  assign acq.busy = (s_ff.state != IDLE);
endmodule
`default_nettype wire

// ==== rtl/dpll_translation_mode_control.sv ====
// Purpose: Translation profile registers and mode control for two DPLL channels
// Assumes: APB slave, no wait states on any transfer; stamps synchronous to pclk
// Notes: Engines apply buildout or hitless acquisition per active profile
`timescale 1ns/10ps
`default_nettype none
module dpll_translation_mode_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0][15:0] ref_stamp,
  input wire logic [1:0][15:0] fb_stamp,
  output logic [1:0][4:0] source_sel,
  output logic [1:0][4:0] feedback_sel,
  output logic [1:0][1:0] mode_active,
  output logic [1:0][15:0] buildout_offset,
  output logic [1:0][15:0] freq_tuning,
  output logic [1:0] hitless_active
);
  typedef struct packed {
    logic [11:0][31:0] prof;
    logic [1:0][2:0] act;
    logic [1:0][31:0] div;
    logic [1:0][31:0] frac;
    logic [1:0][31:0] lim;
    logic [1:0][31:0] freq;
    logic [1:0][15:0] old_ref;
    logic [1:0] start;
    logic [1:0] sw;
    logic [1:0][4:0] src;
    logic [1:0][4:0] fbs;
    logic [1:0][1:0] mode;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } regs_t;
  regs_t s_ff, nxt_s;

  logic [1:0][15:0] e_bo;
  logic [1:0][15:0] e_fadj;
  logic [1:0] e_hl;
  logic [1:0] e_busy;
  logic [1:0][31:0] rnum;
  logic [1:0][31:0] rden;
  logic prof_hit;
  logic ch_hit;
  logic [3:0] pidx;
  logic cidx;
  logic [31:0] rd;
  logic reg_hit;

  acq_if acq [2] ();

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      tm_engine u_eng (
        .pclk(pclk),
        .presetn(presetn),
        .acq(acq[g])
      );
      assign acq[g].start = s_ff.start[g];
      assign acq[g].mode = s_ff.mode[g];
      // Switchover in buildout takes old-to-new reference stamp difference
      assign acq[g].offset = (s_ff.sw[g] && s_ff.mode[g] != dpll_tm_pkg::MODE_INT_ZD &&
                              s_ff.mode[g] != dpll_tm_pkg::MODE_EXT_ZD) ?
                             16'(ref_stamp[g] - s_ff.old_ref[g]) :
                             16'(ref_stamp[g] - fb_stamp[g]);
      assign acq[g].period = s_ff.freq[g][31:16];
      assign acq[g].slew = s_ff.lim[g][15:0];
      assign acq[g].clamp = s_ff.lim[g][31:16];
      assign acq[g].freq_in = s_ff.freq[g][15:0];
      assign e_bo[g] = acq[g].bo;
      assign e_fadj[g] = acq[g].fadj;
      assign e_hl[g] = acq[g].hitless;
      assign e_busy[g] = acq[g].busy;
    end
  endgenerate

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b +: 8] = wd[8*b +: 8];
    end
    wmerge = r;
  endfunction

  function automatic logic [3:0] pindex(input logic ch, input logic [2:0] i);
    pindex = (ch ? 4'h6 : 4'h0) + {1'b0, i};
  endfunction

  // Frequency ratio readback, numerator over denominator
  always_comb begin
    logic [7:0] n_int;
    logic [7:0] m_div;
    logic [7:0] r_div;
    logic [7:0] q_div;
    logic [7:0] f_num;
    logic [7:0] f_mod;
    n_int = 8'h00;
    m_div = 8'h00;
    r_div = 8'h00;
    q_div = 8'h00;
    f_num = 8'h00;
    f_mod = 8'h00;
    for (int c = 0; c < 2; c++) begin
      n_int = s_ff.div[c][7:0];
      m_div = s_ff.div[c][15:8];
      r_div = s_ff.div[c][23:16];
      q_div = s_ff.div[c][31:24];
      f_num = s_ff.frac[c][7:0];
      f_mod = s_ff.frac[c][15:8];
      if (s_ff.src[c] == dpll_tm_pkg::SRC_FB_A || s_ff.src[c] == dpll_tm_pkg::SRC_FB_B ||
          s_ff.src[c] == dpll_tm_pkg::SRC_NCO0 || s_ff.src[c] == dpll_tm_pkg::SRC_NCO1) begin
        r_div = 8'h01;
      end
      if (s_ff.mode[c] == dpll_tm_pkg::MODE_INT_ZD || s_ff.mode[c] == dpll_tm_pkg::MODE_EXT_ZD) begin
        rnum[c] = {24'h000000, n_int};
        rden[c] = {24'h000000, r_div};
      end else begin
        rnum[c] = 32'((({8'h00, n_int} * {8'h00, f_mod}) + {16'h0000, f_num}) * m_div);
        rden[c] = 32'({r_div, 1'b0} * q_div * f_mod);
      end
    end
  end

  // Address decode and read mux
  always_comb begin
    prof_hit = 1'b0;
    ch_hit = 1'b0;
    pidx = 4'h0;
    cidx = paddr[8];
    rd = 32'h00000000;
    reg_hit = 1'b0;
    if ((paddr[15:8] == dpll_tm_pkg::PROF_BASE0[15:8] ||
         paddr[15:8] == dpll_tm_pkg::PROF_BASE1[15:8]) &&
        paddr[7:0] < dpll_tm_pkg::PROF_END && paddr[4:0] == 5'h00) begin
      prof_hit = 1'b1;
      pidx = pindex(paddr[15:8] == dpll_tm_pkg::PROF_BASE1[15:8], paddr[7:5]);
      rd = s_ff.prof[pidx] & dpll_tm_pkg::PROF_MASK;
      reg_hit = 1'b1;
    end else if (paddr[15:9] == dpll_tm_pkg::CH_BASE[15:9] && paddr[1:0] == 2'h0) begin
      ch_hit = 1'b1;
      reg_hit = 1'b1;
      case (paddr[7:0])
        dpll_tm_pkg::OFS_CTRL: rd = {29'h00000000, s_ff.act[cidx]};
        dpll_tm_pkg::OFS_DIV: rd = s_ff.div[cidx];
        dpll_tm_pkg::OFS_FRAC: rd = {16'h0000, s_ff.frac[cidx][15:0]};
        dpll_tm_pkg::OFS_LIMIT: rd = s_ff.lim[cidx];
        dpll_tm_pkg::OFS_FREQ: rd = s_ff.freq[cidx];
        dpll_tm_pkg::OFS_STAT: rd = {16'h0000, s_ff.fbs[cidx], s_ff.src[cidx],
                                     s_ff.mode[cidx], e_busy[cidx], e_hl[cidx]};
        dpll_tm_pkg::OFS_BO: rd = {{16{e_bo[cidx][15]}}, e_bo[cidx]};
        dpll_tm_pkg::OFS_FADJ: rd = {{16{e_fadj[cidx][15]}}, e_fadj[cidx]};
        dpll_tm_pkg::OFS_RNUM: rd = rnum[cidx];
        dpll_tm_pkg::OFS_RDEN: rd = rden[cidx];
        default: reg_hit = 1'b0;
      endcase
    end
  end

  always_comb begin
    logic [2:0] want;
    logic [3:0] wi;
    want = 3'h0;
    wi = 4'h0;
    nxt_s = s_ff;
    nxt_s.start = 2'b00;
    nxt_s.sw = 2'b00;
    nxt_s.ready = 1'b0;
    // Answer one cycle after setup; data and error captured in setup
    if (psel && !penable) begin
      nxt_s.ready = 1'b1;
      nxt_s.err = !reg_hit;
      nxt_s.rdata = (reg_hit && !pwrite) ? rd : 32'h00000000;
    end
    // Old stamp freezes through the switch so the offset sees both references
    for (int c = 0; c < 2; c++) begin
      if (!s_ff.sw[c] && !s_ff.start[c]) nxt_s.old_ref[c] = ref_stamp[c];
    end
    if (psel && penable && s_ff.ready && pwrite && !s_ff.err) begin
      if (prof_hit) begin
        nxt_s.prof[pidx] = wmerge(s_ff.prof[pidx], pwdata, pstrb) & dpll_tm_pkg::PROF_MASK;
      end else if (ch_hit) begin
        case (paddr[7:0])
          dpll_tm_pkg::OFS_CTRL: begin
            if (pstrb[0]) begin
              want = pwdata[2:0];
              wi = pindex(cidx, want);
              // Disabled or out-of-range profiles are never selected
              if (want < 3'h6 && s_ff.prof[wi][dpll_tm_pkg::EN_BIT]) begin
                if (want != s_ff.act[cidx]) begin
                  nxt_s.act[cidx] = want;
                  nxt_s.start[cidx] = 1'b1;
                  nxt_s.sw[cidx] = 1'b1;
                end else if (pwdata[dpll_tm_pkg::ACQ_BIT]) begin
                  nxt_s.start[cidx] = 1'b1;
                end
              end
            end
          end
          dpll_tm_pkg::OFS_DIV: nxt_s.div[cidx] = wmerge(s_ff.div[cidx], pwdata, pstrb);
          dpll_tm_pkg::OFS_FRAC: nxt_s.frac[cidx] = wmerge(s_ff.frac[cidx], pwdata, pstrb);
          dpll_tm_pkg::OFS_LIMIT: nxt_s.lim[cidx] = wmerge(s_ff.lim[cidx], pwdata, pstrb);
          dpll_tm_pkg::OFS_FREQ: nxt_s.freq[cidx] = wmerge(s_ff.freq[cidx], pwdata, pstrb);
          default: nxt_s.err = s_ff.err;
        endcase
      end
    end
    // Copy active profile fields using the next selection so mode and start align
    for (int c = 0; c < 2; c++) begin
      wi = pindex(c[0], nxt_s.act[c]);
      nxt_s.mode[c] = nxt_s.prof[wi][dpll_tm_pkg::MODE_LSB +: 2];
      nxt_s.src[c] = nxt_s.prof[wi][dpll_tm_pkg::SRC_LSB +: 5];
      nxt_s.fbs[c] = nxt_s.prof[wi][dpll_tm_pkg::FBS_LSB +: 5];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
      s_ff.div <= {dpll_tm_pkg::DIV_RST, dpll_tm_pkg::DIV_RST};
      s_ff.frac <= {dpll_tm_pkg::FRAC_RST, dpll_tm_pkg::FRAC_RST};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.rdata;
  assign pready = s_ff.ready;
  assign pslverr = s_ff.err & s_ff.ready;
  assign source_sel = s_ff.src;
  assign feedback_sel = s_ff.fbs;
  assign mode_active = s_ff.mode;
  assign buildout_offset = e_bo;
  assign freq_tuning = e_fadj;
  assign hitless_active = e_hl;
endmodule
`default_nettype wire

// ==== sim/tm_ctl_props.sv ====
// Purpose: Port properties of the translation mode control block
// Assumes: Single clock, async active-low reset
// Notes: Channel 0 is watched; channel 1 shares the same logic
`timescale 1ns/10ps
`default_nettype none
module tm_ctl_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0][1:0] mode_active,
  input wire logic [1:0][15:0] buildout_offset,
  input wire logic [1:0] hitless_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && pready;
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse) else $error("pready too long");
  property p_rdy_next;
    psel && !penable |=> psel && penable && pready;
  endproperty
  a_rdy_next: assert property (p_rdy_next) else $error("no answer to setup");
  property p_err_gap;
    acc && paddr[15:12] == 4'h1 && paddr[4:0] != 5'h00 |-> pslverr;
  endproperty
  a_err_gap: assert property (p_err_gap) else $error("gap byte accepted");
  property p_prof_ok;
    acc && paddr[15:8] inside {8'h12, 8'h16} && paddr[7:0] < 8'hC0 && paddr[4:0] == 5'h00
      |-> !pslverr;
  endproperty
  a_prof_ok: assert property (p_prof_ok) else $error("profile refused");
  property p_err_data;
    pready && pslverr && !pwrite |-> prdata == 32'h00000000;
  endproperty
  a_err_data: assert property (p_err_data) else $error("refused read not zero");
  property p_zd_hitless;
    $rose(hitless_active[0]) |-> mode_active[0][0];
  endproperty
  a_zd_hitless: assert property (p_zd_hitless) else $error("hitless in buildout");
  property p_mode_cause;
    $changed(mode_active[0]) |-> $past(psel, 1) || $past(psel, 2) || $past(psel, 3);
  endproperty
  a_mode_cause: assert property (p_mode_cause) else $error("mode moved alone");
  // Offset must not drift back once inserted, only a new acquisition moves it
  property p_bo_hold;
    (!psel && !hitless_active[0]) [*3] |=> $stable(buildout_offset[0]);
  endproperty
  a_bo_hold: assert property (p_bo_hold) else $error("buildout offset drifted");
  property p_hl_end;
    $fell(hitless_active[0]) |-> buildout_offset[0] == 16'h0000 || $past(psel, 2);
  endproperty
  a_hl_end: assert property (p_hl_end) else $error("hitless ended off phase");
  c_hitless: cover property ($rose(hitless_active[0]));
  c_refused: cover property (pready && pslverr);
  c_buildout: cover property ($changed(buildout_offset[0]) && !hitless_active[0]);
endmodule
bind dpll_translation_mode_control tm_ctl_props chk_i (.pclk(pclk), .presetn(presetn),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .mode_active(mode_active),
  .buildout_offset(buildout_offset), .hitless_active(hitless_active));
`default_nettype wire

// ==== sim/stamp_src.sv ====
// Purpose: Reference and feedback time stamp sources
// Assumes: Stamps advance one count per pclk like a running converter
// Notes: One shared timebase, so the skew between them never drifts
`timescale 1ns/10ps
`default_nettype none
module stamp_src #(
  parameter logic [15:0] REF_SKEW = 16'h00BE,
  parameter logic [15:0] FB_SKEW = 16'h0064
) (
  input wire logic pclk,
  output logic [1:0][15:0] ref_stamp,
  output logic [1:0][15:0] fb_stamp
);
  logic [15:0] tick_ff = 16'h0000;
  always_ff @(posedge pclk) begin
    tick_ff <= tick_ff + 16'h0001;
  end
  assign ref_stamp = {2{tick_ff + REF_SKEW}};
  assign fb_stamp = {2{tick_ff + FB_SKEW}};
endmodule
`default_nettype wire

// ==== sim/test_dpll_translation_mode_control.sv ====
// Purpose: Self-checking bench for the translation mode control block
// Assumes: APB answers after one access cycle; stamps differ by 90
// Notes: Channel 0 is exercised; byte strobes stay all-on
`timescale 1ns/10ps
`default_nettype none
module test_dpll_translation_mode_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0][15:0] ref_stamp;
  logic [1:0][15:0] fb_stamp;
  logic [1:0][4:0] source_sel;
  logic [1:0][1:0] mode_active;
  logic [1:0][15:0] buildout_offset;
  logic [1:0][15:0] freq_tuning;
  logic [1:0] hitless_active;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [1:0] md[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
  logic [15:0] cl[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0003};
  logic [31:0] rp[7] = '{32'h1, 32'h401, 32'h501, 32'h801, 32'h901, 32'h1000001, 32'h3000801};
  logic [31:0] rn[7] = '{32'h1A, 32'h1A, 32'h1A, 32'h1A, 32'h1A, 32'h3, 32'h3};
  logic [31:0] rdn[7] = '{32'h118, 32'h38, 32'h38, 32'h38, 32'h38, 32'h5, 32'h1};
  initial begin
    forever #2 pclk = ~pclk;
  end
  stamp_src src_i (.pclk(pclk), .ref_stamp(ref_stamp), .fb_stamp(fb_stamp));
  dpll_translation_mode_control uut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ref_stamp(ref_stamp),
    .fb_stamp(fb_stamp), .source_sel(source_sel), .feedback_sel(), .mode_active(mode_active),
    .buildout_offset(buildout_offset), .freq_tuning(freq_tuning),
    .hitless_active(hitless_active));
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Answer is taken at the rising edge where pready is sampled high, then released
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk($sformatf("wr err %h", a), 32'h0, {31'h0, e});
  endtask
  task automatic rd(input logic [15:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk($sformatf("rd %h", a), x, r);
    chk($sformatf("rd err %h", a), {31'h0, xe}, {31'h0, e});
  endtask
  initial begin
    logic signed [15:0] bo, pb, ft, lim;
    logic [31:0] r;
    logic e;
    logic hl;
    int bad, neg, n;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(16'h1200, 32'h0, 1'b0);
    rd(16'h2004, 32'h01010101, 1'b0);
    rd(16'h2008, 32'h00000100, 1'b0);
    rd(16'h16A0, 32'h0, 1'b0);
    rd(16'h1204, 32'h0, 1'b1);
    rd(16'h12C0, 32'h0, 1'b1);
    apb(1'b1, 16'h1223, 32'hFFFFFFFF, r, e);
    chk("misaligned wr", 32'h1, {31'h0, e});
    wr(16'h1220, 32'hFFFFFFFF);
    rd(16'h1220, 32'h031F1F3F, 1'b0);
    wr(16'h2010, 32'h00640000);
    wr(16'h1220, 32'h00000001);
    wr(16'h2000, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      hl = md[i][0];
      lim = (cl[i] == 16'h0000) ? 16'h0010 : cl[i];
      wr(16'h200C, {cl[i], 16'h0010});
      wr(16'h1220, {6'h00, md[i], 24'h000001});
      wr(16'h2000, 32'h00000009);
      repeat (3) @(negedge pclk);
      chk("mode", {30'h0, md[i]}, {30'h0, mode_active[0]});
      chk("hitless", {31'h0, hl}, {31'h0, hitless_active[0]});
      bad = 0;
      neg = 0;
      n = 0;
      pb = buildout_offset[0];
      while (hitless_active[0] === 1'b1 && n < 400) begin
        @(negedge pclk);
        ft = freq_tuning[0];
        bo = buildout_offset[0];
        if (ft > 16'sh0000 || ft < -lim) bad++;
        if (ft < 16'sh0000) neg++;
        if (bo - pb > 16'sh0010 || pb - bo > 16'sh0010) bad++;
        pb = bo;
        n++;
      end
      chk("slew", 32'h0, bad);
      chk("steer", {31'h0, hl}, {31'h0, neg > 0});
      repeat (20) @(negedge pclk);
      bo = buildout_offset[0];
      chk("bo", hl ? 32'h0 : 32'h5A, {{16{bo[15]}}, bo});
    end
    wr(16'h1240, 32'h03000000);
    for (int i = 2; i < 7; i += 4) begin
      wr(16'h2000, {29'h0, 3'(i)});
      repeat (3) @(negedge pclk);
      chk("kept mode", 32'h1, {30'h0, mode_active[0]});
    end
    wr(16'h2004, 32'h07050203);
    wr(16'h2008, 32'h00000401);
    wr(16'h2020, 32'hFFFFFFFF);
    for (int i = 0; i < 7; i++) begin
      wr(16'h1220, rp[i]);
      wr(16'h2000, 32'h00000009);
      repeat (3) @(negedge pclk);
      chk("src", {27'h0, rp[i][12:8]}, {27'h0, source_sel[0]});
      rd(16'h2020, rn[i], 1'b0);
      rd(16'h2024, rdn[i], 1'b0);
    end
    complete_run();
  end
endmodule
`default_nettype wire
